// file: hw/irq_enable_clear_regs.sv
// axi4-lite register block holding per-interrupt enable state with set and clear words
//
// The address map and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps
module irq_enable_clear_regs (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [49:0] irqEnable
);
   // captured write address and data, with held flags
   logic [7:0] wrAddr;
   logic [7:0] next_wrAddr;
   logic [31:0] wrData;
   logic [31:0] next_wrData;
   logic haveAddr;
   logic next_haveAddr;
   logic haveData;
   logic next_haveData;
   logic [1:0] next_bresp;
   logic next_bvalid;
   logic [31:0] next_rdata;
   logic [1:0] next_rresp;
   logic next_rvalid;
   // enable words and their strobes
   logic [31:0] enableLow;
   logic [31:0] enableHigh;
   logic doWrite;
   logic setLowStb;
   logic setHighStb;
   logic clrLowStb;
   logic clrHighStb;
   // true when the address hits one of the four words
   function automatic logic isMapped(input logic [7:0] addr);
      isMapped = (addr == iec_pkg::ENABLE_SET_LOW_OFFSET)
              || (addr == iec_pkg::ENABLE_SET_HIGH_OFFSET)
              || (addr == iec_pkg::ENABLE_CLEAR_LOW_OFFSET)
              || (addr == iec_pkg::ENABLE_CLEAR_HIGH_OFFSET);
   endfunction : isMapped

   // accept address and data in either order; hold each until both arrived
   assign s_axi_awready = !haveAddr && !s_axi_bvalid;
   assign s_axi_wready = !haveData && !s_axi_bvalid;
   // read address taken only while no read answer is outstanding
   assign s_axi_arready = !s_axi_rvalid;
   assign doWrite = haveAddr && haveData && !s_axi_bvalid;

   // bytes not strobed count as zero, so they never disturb an enable;
   // masking at capture means the strobes need not be stored with the data
   function automatic logic [31:0] laneDataNow(input logic [31:0] d, input logic [3:0] s);
      logic [31:0] m;
      m = 32'h0000_0000;
      for (int i = 0; i < 4; i++) begin
         m[i*8 +: 8] = s[i] ? 8'hFF : 8'h00;
      end
      laneDataNow = d & m;
   endfunction : laneDataNow

   // strobes into the two enable words
   assign setLowStb = doWrite && (wrAddr == iec_pkg::ENABLE_SET_LOW_OFFSET);
   assign setHighStb = doWrite && (wrAddr == iec_pkg::ENABLE_SET_HIGH_OFFSET);
   assign clrLowStb = doWrite && (wrAddr == iec_pkg::ENABLE_CLEAR_LOW_OFFSET);
   assign clrHighStb = doWrite && (wrAddr == iec_pkg::ENABLE_CLEAR_HIGH_OFFSET);

   // low word: interrupts 0-4 and 6-31
   iec_enable_word #(
      .IMPL_MASK(iec_pkg::LOW_IMPL_MASK)
   ) lowWord (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .setStrobe(setLowStb),
      .clearStrobe(clrLowStb),
      .writeData(wrData),
      .enableState(enableLow)
   );

   // high word: interrupts 32-33, 40-42 and 49
   iec_enable_word #(
      .IMPL_MASK(iec_pkg::HIGH_IMPL_MASK)
   ) highWord (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .setStrobe(setHighStb),
      .clearStrobe(clrHighStb),
      .writeData(wrData),
      .enableState(enableHigh)
   );

   // flat per-interrupt enable vector for the pending and priority logic
   always_comb begin
      irqEnable = {enableHigh[17:0], enableLow};
   end

   // write channel next values
   always_comb begin
      next_wrAddr = wrAddr;
      next_wrData = wrData;
      next_haveAddr = haveAddr;
      next_haveData = haveData;
      next_bresp = s_axi_bresp;
      next_bvalid = s_axi_bvalid;
      // address beat
      if (s_axi_awvalid && s_axi_awready) begin
         next_wrAddr = s_axi_awaddr;
         next_haveAddr = 1'b1;
      end
      // data beat, masked by byte strobes at capture
      if (s_axi_wvalid && s_axi_wready) begin
         next_wrData = laneDataNow(s_axi_wdata, s_axi_wstrb);
         next_haveData = 1'b1;
      end
      // both parts present: perform and answer
      if (doWrite) begin
         next_haveAddr = 1'b0;
         next_haveData = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = isMapped(wrAddr) ? iec_pkg::RESP_OKAY : iec_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
         next_bvalid = 1'b0;
      end
   end

   // write channel registers
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         wrAddr <= 8'h00;
         wrData <= 32'h0000_0000;
         haveAddr <= 1'b0;
         haveData <= 1'b0;
         s_axi_bresp <= 2'b00;
         s_axi_bvalid <= 1'b0;
      end else begin
         wrAddr <= next_wrAddr;
         wrData <= next_wrData;
         haveAddr <= next_haveAddr;
         haveData <= next_haveData;
         s_axi_bresp <= next_bresp;
         s_axi_bvalid <= next_bvalid;
      end
   end

   // read channel: both set and clear words show the live enable state
   always_comb begin
      next_rdata = s_axi_rdata;
      next_rresp = s_axi_rresp;
      next_rvalid = s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
         next_rvalid = 1'b1;
         next_rresp = iec_pkg::RESP_OKAY;
         unique case (s_axi_araddr)
            iec_pkg::ENABLE_SET_LOW_OFFSET,
            iec_pkg::ENABLE_CLEAR_LOW_OFFSET: begin
               next_rdata = enableLow & iec_pkg::LOW_IMPL_MASK;
            end
            iec_pkg::ENABLE_SET_HIGH_OFFSET,
            iec_pkg::ENABLE_CLEAR_HIGH_OFFSET: begin
               next_rdata = enableHigh & iec_pkg::HIGH_IMPL_MASK;
            end
            default: begin
               // unmapped: zero data with slave error
               next_rdata = 32'h0000_0000;
               next_rresp = iec_pkg::RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         next_rvalid = 1'b0;
      end
   end

   // read channel registers
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= 2'b00;
         s_axi_rvalid <= 1'b0;
      end else begin
         s_axi_rdata <= next_rdata;
         s_axi_rresp <= next_rresp;
         s_axi_rvalid <= next_rvalid;
      end
   end
endmodule : irq_enable_clear_regs

// file: hw/iec_pkg.sv
// package: register map, bit masks and reset values of the interrupt enable block
package iec_pkg;
   // byte offsets of the registers (no offsets given, so chosen here)
   localparam logic [7:0] ENABLE_SET_LOW_OFFSET = 8'h00;
   localparam logic [7:0] ENABLE_SET_HIGH_OFFSET = 8'h04;
   localparam logic [7:0] ENABLE_CLEAR_LOW_OFFSET = 8'h08;
   localparam logic [7:0] ENABLE_CLEAR_HIGH_OFFSET = 8'h0C;
   // decoded address width
   localparam int ADDR_BITS = 8;
   // implemented bits: low word is interrupts 0-4 and 6-31
   localparam logic [31:0] LOW_IMPL_MASK = 32'hFFFF_FFDF;
   // high word: bit 17 is irq 49, bits 10-8 irq 42-40, bits 1-0 irq 33-32
   localparam logic [31:0] HIGH_IMPL_MASK = 32'h0002_0703;
   // every enable is off after reset
   localparam logic [31:0] ENABLE_RESET = 32'h0000_0000;
   // axi response codes
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : iec_pkg

// file: hw/iec_enable_word.sv
// one 32-bit word of interrupt enable state with set and clear strobes
`timescale 1ns/1ps
module iec_enable_word #(
   parameter logic [31:0] IMPL_MASK = 32'hFFFF_FFFF
) (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic setStrobe,
   input wire logic clearStrobe,
   input wire logic [31:0] writeData,
   output logic [31:0] enableState
);
   // next enable state
   logic [31:0] next_enableState;

   // ones set or clear bits, zeros leave them alone; only implemented bits change
   always_comb begin
      next_enableState = enableState;
      if (setStrobe) begin
         next_enableState = next_enableState | (writeData & IMPL_MASK);
      end
      if (clearStrobe) begin
         next_enableState = next_enableState & ~(writeData & IMPL_MASK);
      end
   end

   // register the state; reset leaves all interrupts disabled
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         enableState <= iec_pkg::ENABLE_RESET;
      end else begin
         enableState <= next_enableState;
      end
   end
endmodule : iec_enable_word

// file: bench/iec_checker_properties.sv
// checker: bus answers and enable bookkeeping of the interrupt enable block
`timescale 1ns/1ps
module iec_checker (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [49:0] irqEnable
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   // both write beats at one edge; the bench always offers them together
   wire wrBoth = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   wire rdTake = s_axi_arvalid && s_axi_arready;
   // write data as it acts: bytes without a strobe count as zero
   wire [31:0] wMasked = s_axi_wdata & {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
      {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
   // enables are registered one edge after the beats are held, read data at the accepting edge,
   // so they are sampled settled two edges after the accepting edge
   AST_RESET_OFF: assert property ($rose(reset_n) |-> irqEnable == 50'h0)
      else $error("enables not cleared by reset");
   AST_CLEAR_LOW: assert property (wrBoth && s_axi_awaddr == 8'h08
      |-> ##2 irqEnable[31:0] == ($past(irqEnable[31:0], 2) & ~$past(wMasked, 2)))
      else $error("low clear write wrong");
   AST_SET_LOW: assert property (wrBoth && s_axi_awaddr == 8'h00
      |-> ##2 irqEnable[31:0] == (($past(irqEnable[31:0], 2) | $past(wMasked, 2))
         & 32'hFFFF_FFDF))
      else $error("low set write wrong");
   AST_CLEAR_HIGH: assert property (wrBoth && s_axi_awaddr == 8'h0C
      |-> ##2 irqEnable[42:40] == ($past(irqEnable[42:40], 2) & ~$past(wMasked[10:8], 2)))
      else $error("high clear write wrong");
   AST_ONLY_BY_WRITE: assert property ($changed(irqEnable) |-> $rose(s_axi_bvalid))
      else $error("enables moved without a write");
   AST_READ_LOW: assert property (rdTake && s_axi_araddr == 8'h08
      |-> ##2 s_axi_rdata == $past(irqEnable[31:0], 2))
      else $error("low read wrong");
   AST_READ_HIGH: assert property (rdTake && s_axi_araddr == 8'h0C
      |-> ##2 s_axi_rdata == {14'h0, $past(irqEnable[49], 2), 6'h0, $past(irqEnable[42:40], 2),
         6'h0, $past(irqEnable[33:32], 2)})
      else $error("high read wrong");
   AST_RESERVED_ZERO: assert property (irqEnable[5] == 1'b0
      && irqEnable[39:34] == 6'h0 && irqEnable[48:43] == 6'h0)
      else $error("unused enable bit set");
endmodule : iec_checker

// file: bench/irq_enable_clear_regs_tb.sv
// testbench: random register traffic against a reference of the enable bits
`timescale 1ns/1ps
module irq_enable_clear_regs_tb;
   logic sys_clk, reset_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [49:0] irqEnable, model; // model: reference enable per interrupt
   logic [7:0] offs[5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10}; // last one unmapped
   int num_errors = 0, checks = 0;
   irq_enable_clear_regs irq_enable_clear_regs_i (.*);
   task automatic chk(input string what, input logic [49:0] seen, input logic [49:0] exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic tally_and_finish;
      if (num_errors == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : tally_and_finish
   // expected word: set and clear words read alike, unmapped reads zero
   function automatic logic [31:0] view(input logic [7:0] a);
      if (a[7:4] != 4'h0) return 32'h0000_0000;
      if (a[2]) return {14'h0, model[49], 6'h0, model[42:40], 6'h0, model[33:32]};
      return model[31:0];
   endfunction : view
   // write with address and data offered together, released as each is taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [49:0] v;
      logic [3:0] s;
      logic [31:0] m;
      // full strobes half the time, otherwise a random lane mix
      s = ($urandom % 2) ? 4'hF : 4'($urandom);
      // bytes left out by the strobes must not touch an enable
      m = d & {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
      v = a[2] ? {m[17], 6'h0, m[10:8], 6'h0, m[1:0], 32'h0000_0000} : 50'(m);
      @(posedge sys_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      chk("bresp", 50'(s_axi_bresp), 50'(a[7:4] != 4'h0 ? 2'b10 : 2'b00));
      if (a[7:4] == 4'h0) model = a[3] ? model & ~v : model | v;
      chk("enables", irqEnable, model);
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge sys_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      chk("rdata", 50'(s_axi_rdata), 50'(view(a)));
      chk("rresp", 50'(s_axi_rresp), 50'(a[7:4] != 4'h0 ? 2'b10 : 2'b00));
   endtask : rd
   // 40 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   // hang guard, far beyond the fewer than one thousand cycles the run needs
   initial begin
      repeat (20000) @(posedge sys_clk);
      num_errors++;
      tally_and_finish();
   end
   initial begin
      logic [7:0] o;
      {reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hF;
      model = '0;
      void'($urandom(29));
      repeat (6) @(posedge sys_clk);
      reset_n <= 1'b1;
      // second pass starts from a reset taken in mid-run
      for (int p = 0; p < 2; p++) begin
         for (int i = 0; i < 5; i++) rd(offs[i]);
         for (int i = 0; i < 60; i++) begin
            o = offs[$urandom % 5];
            // reserved bits kept zero, as software must
            wr(o, $urandom & (o[2] ? 32'h0002_0703 : 32'hFFFF_FFDF));
            rd(offs[$urandom % 5]);
         end
         @(posedge sys_clk);
         reset_n <= 1'b0;
         model = '0;
         repeat (2) @(posedge sys_clk);
         reset_n <= 1'b1;
      end
      tally_and_finish();
   end
endmodule : irq_enable_clear_regs_tb
bind irq_enable_clear_regs iec_checker iec_checker_i (.*);
